// file: rtl/gauge_cmd_pkg.sv
// Constants shared by the serial gauge command parser.
package gauge_cmd_pkg;

  localparam int unsigned MAX_CHAN = 10;
  localparam int unsigned ADDR_W = 6;
  localparam int unsigned DBUF_DEPTH = 8;
  localparam logic [4:0] MAX_DATA_LEN = 5'h1A;
  localparam logic [4:0] DATA_LEN_SAT = 5'h1B;
  localparam logic [2:0] PRESS_CHARS = 3'h6;

  localparam logic [7:0] CH_AT = 8'h40;
  localparam logic [7:0] CH_COLON = 8'h3A;
  localparam logic [7:0] CH_QUEST = 8'h3F;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_0 = 8'h30;
  localparam logic [7:0] CH_1 = 8'h31;
  localparam logic [7:0] CH_2 = 8'h32;
  localparam logic [7:0] CH_3 = 8'h33;
  localparam logic [7:0] CH_4 = 8'h34;
  localparam logic [7:0] CH_5 = 8'h35;
  localparam logic [7:0] CH_9 = 8'h39;
  localparam logic [7:0] CH_A = 8'h41;
  localparam logic [7:0] CH_D = 8'h44;
  localparam logic [7:0] CH_E = 8'h45;
  localparam logic [7:0] CH_F = 8'h46;
  localparam logic [7:0] CH_H = 8'h48;
  localparam logic [7:0] CH_K = 8'h4B;
  localparam logic [7:0] CH_L = 8'h4C;
  localparam logic [7:0] CH_M = 8'h4D;
  localparam logic [7:0] CH_N = 8'h4E;
  localparam logic [7:0] CH_O = 8'h4F;
  localparam logic [7:0] CH_P = 8'h50;
  localparam logic [7:0] CH_LOW_A = 8'h61;
  localparam logic [7:0] CH_LOW_Z = 8'h7A;
  localparam logic [7:0] CH_DOT = 8'h2E;
  localparam logic [7:0] CH_PLUS = 8'h2B;
  localparam logic [7:0] CH_MINUS = 8'h2D;

  // Command codes: category as two characters, number as one.
  localparam logic [15:0] CAT_POWER = 16'h3038;
  localparam logic [15:0] CAT_FORMAT = 16'h3530;
  localparam logic [7:0] NUM_FORMAT = 8'h38;
  localparam logic [15:0] CAT_DIAG = 16'h3939;
  localparam logic [7:0] NUM_CONFIG = 8'h32;
  localparam logic [15:0] CAT_CAL = 16'h3037;
  localparam logic [7:0] NUM_ZERO = 8'h31;
  localparam logic [7:0] NUM_SPAN = 8'h32;
  localparam logic [15:0] CAT_CTRL = 16'h3330;
  localparam logic [7:0] NUM_MODE = 8'h31;

  // Register byte offsets.
  localparam logic [5:0] REG_STATUS = 6'h00;
  localparam logic [5:0] REG_PRESENT = 6'h04;
  localparam logic [5:0] REG_HOT_CATH = 6'h08;
  localparam logic [5:0] REG_ION = 6'h0C;
  localparam logic [5:0] REG_KEEP_SUPPLY = 6'h10;
  localparam logic [5:0] REG_ZERO_EN = 6'h14;
  localparam logic [5:0] REG_SPAN_EN = 6'h18;
  localparam logic [5:0] REG_THERMAL = 6'h1C;
  localparam logic [5:0] REG_GAS_N2 = 6'h20;
  localparam logic [5:0] REG_MISC = 6'h24;
  localparam logic [5:0] REG_POWER = 6'h28;
  localparam logic [5:0] REG_AUTO_POWER = 6'h2C;
  localparam logic [5:0] REG_SLOTS = 6'h30;

  // Every state bit, register and stored setting resets to zero.
  localparam logic [1:0] RST_CTRL_MODE = 2'h0;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_HDR = 3'b001,
    ST_TAIL = 3'b010,
    ST_DATA = 3'b011,
    ST_QEND = 3'b100,
    ST_SKIP = 3'b101,
    ST_EXEC = 3'b110,
    ST_SEND = 3'b111
  } st_t;

  typedef enum logic [1:0] {
    KIND_CMD = 2'b00,
    KIND_DATA = 2'b01,
    KIND_REQ = 2'b10
  } kind_t;

  typedef enum logic [1:0] {
    ERR_NONE = 2'b00,
    ERR_UNREC = 2'b01,
    ERR_INAPP = 2'b10,
    ERR_DATA = 2'b11
  } err_t;

endpackage

// file: rtl/serial_gauge_command_parser.sv
// Message framing, command decoding, channel state and reply generation.
//
// Chosen here: the register addresses and the plain strobed port.
module serial_gauge_command_parser #(
  parameter int unsigned NUM_CHAN = 10,
  parameter int unsigned SLOT_COUNT = 4
) (
  input wire logic mclk_in,
  input wire logic reset_n_in,
  input wire logic [7:0] rx_data_in,
  input wire logic rx_valid_in,
  output logic rx_ready_out,
  output logic [7:0] tx_data_out,
  output logic tx_valid_out,
  input wire logic tx_ready_in,
  input wire logic [gauge_cmd_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  output logic [9:0] chan_power_out,
  output logic [9:0] chan_supply_out,
  output logic [9:0] auto_power_out,
  output logic [9:0][3:0] ref_chan_out,
  output logic [9:0][5:0][7:0] shutoff_press_out,
  output logic [9:0][2:0] shutoff_len_out,
  output logic fmt_sci_out,
  output logic degas_active_out,
  output logic degas_high_out,
  output logic [3:0] degas_chan_out,
  output logic [1:0] ctrl_mode_out
);
  import gauge_cmd_pkg::*;

  typedef struct packed {
    st_t st;
    kind_t kind;
    logic [3:0][7:0] hdr;
    logic [1:0] hcnt;
    logic bad;
    logic lower;
    logic [7:0][7:0] dbuf;
    logic [4:0] dlen;
    logic [7:0][7:0] pay;
    logic [3:0] plen;
    logic [3:0] tidx;
    logic [7:0] txb;
    logic fmt_sci;
    logic [9:0] power;
    logic [9:0] autopwr;
    logic [9:0][3:0] refch;
    logic [9:0][5:0][7:0] press;
    logic [9:0][2:0] press_len;
    logic degas_on;
    logic degas_hi;
    logic [3:0] degas_ch;
    logic [1:0] ctrl_mode;
    logic [9:0] present;
    logic [9:0] hot;
    logic [9:0] ion;
    logic [9:0] keep;
    logic [9:0] zero_en;
    logic [9:0] span_en;
    logic [9:0] thermal;
    logic [9:0] n2;
    logic recipe_none;
    logic [31:0] slots;
    logic [31:0] rdata;
  } state_t;

  state_t q;
  state_t d;

  // Byte number i of the outgoing reply: '@', header, ':', payload, CR.
  function automatic logic [7:0] reply_byte(input state_t s,
                                            input logic [3:0] i);
    logic [7:0] b;
    logic [3:0] k;
    k = i - 4'h6;
    if (i == 4'h0) begin
      b = CH_AT;
    end else if (i < 4'h5) begin
      b = s.hdr[2'(i - 4'h1)];
    end else if (i == 4'h5) begin
      b = CH_COLON;
    end else if (k < s.plen) begin
      b = s.pay[3'(k)];
    end else begin
      b = CH_CR;
    end
    return b;
  endfunction

  function automatic logic is_digit(input logic [7:0] c);
    return (c >= CH_0) && (c <= CH_9);
  endfunction

  assign rx_ready_out = (q.st != ST_EXEC) && (q.st != ST_SEND);
  assign tx_valid_out = (q.st == ST_SEND);
  assign tx_data_out = q.txb;
  assign reg_rdata_out = q.rdata;
  assign chan_power_out = q.power;
  assign chan_supply_out = q.power | q.keep;
  assign auto_power_out = q.autopwr;
  assign ref_chan_out = q.refch;
  assign shutoff_press_out = q.press;
  assign shutoff_len_out = q.press_len;
  assign fmt_sci_out = q.fmt_sci;
  assign degas_active_out = q.degas_on;
  assign degas_high_out = q.degas_hi;
  assign degas_chan_out = q.degas_ch;
  assign ctrl_mode_out = q.ctrl_mode;

  always_comb begin
    logic rx_fire;
    logic at_seen;
    logic [7:0] b;
    logic [15:0] cat;
    logic [7:0] num;
    logic [7:0] d0;
    logic idok;
    logic inr;
    logic [3:0] ch;
    logic numeric;
    logic known;
    logic is_on;
    logic is_off;
    err_t err;
    rx_fire = 1'b0;
    at_seen = 1'b0;
    b = rx_data_in;
    cat = {q.hdr[0], q.hdr[1]};
    num = q.hdr[2];
    d0 = q.dbuf[0];
    idok = is_digit(q.hdr[3]);
    ch = (q.hdr[3] == CH_0) ? 4'h9 : 4'(q.hdr[3] - CH_1);
    inr = idok && (32'(ch) < NUM_CHAN);
    numeric = (q.dlen != 5'h0) && (q.dlen <= 5'(PRESS_CHARS));
    for (int i = 0; i < int'(PRESS_CHARS); i++) begin
      if ((5'(i) < q.dlen) && !is_digit(q.dbuf[i]) &&
          (q.dbuf[i] != CH_DOT) && (q.dbuf[i] != CH_E) &&
          (q.dbuf[i] != CH_PLUS) && (q.dbuf[i] != CH_MINUS)) begin
        numeric = 1'b0;
      end
    end
    is_on = (q.dlen == 5'h2) && (d0 == CH_O) && (q.dbuf[1] == CH_N);
    is_off = (q.dlen == 5'h3) && (d0 == CH_O) && (q.dbuf[1] == CH_F) &&
             (q.dbuf[2] == CH_F);
    known = ((cat == CAT_POWER) && (num >= CH_1) && (num <= CH_5)) ||
            ((cat == CAT_FORMAT) && (num == NUM_FORMAT)) ||
            ((cat == CAT_DIAG) && (num == NUM_CONFIG)) ||
            ((cat == CAT_CAL) && ((num == NUM_ZERO) ||
                                  (num == NUM_SPAN))) ||
            ((cat == CAT_CTRL) && (num == NUM_MODE));
    err = ERR_NONE;
    d = q;

    // Software view of the channel hardware and the block's state.
    if (reg_wr_in) begin
      case (reg_addr_in)
        REG_PRESENT: d.present = reg_wdata_in[9:0];
        REG_HOT_CATH: d.hot = reg_wdata_in[9:0];
        REG_ION: d.ion = reg_wdata_in[9:0];
        REG_KEEP_SUPPLY: d.keep = reg_wdata_in[9:0];
        REG_ZERO_EN: d.zero_en = reg_wdata_in[9:0];
        REG_SPAN_EN: d.span_en = reg_wdata_in[9:0];
        REG_THERMAL: d.thermal = reg_wdata_in[9:0];
        REG_GAS_N2: d.n2 = reg_wdata_in[9:0];
        REG_MISC: d.recipe_none = reg_wdata_in[0];
        REG_SLOTS: d.slots = reg_wdata_in;
        default: ;
      endcase
    end
    if (reg_rd_in) begin
      case (reg_addr_in)
        REG_STATUS: d.rdata = {22'h0, q.ctrl_mode, q.degas_ch,
                               q.degas_hi, q.degas_on, q.fmt_sci,
                               rx_ready_out};
        REG_PRESENT: d.rdata = {22'h0, q.present};
        REG_HOT_CATH: d.rdata = {22'h0, q.hot};
        REG_ION: d.rdata = {22'h0, q.ion};
        REG_KEEP_SUPPLY: d.rdata = {22'h0, q.keep};
        REG_ZERO_EN: d.rdata = {22'h0, q.zero_en};
        REG_SPAN_EN: d.rdata = {22'h0, q.span_en};
        REG_THERMAL: d.rdata = {22'h0, q.thermal};
        REG_GAS_N2: d.rdata = {22'h0, q.n2};
        REG_MISC: d.rdata = {31'h0, q.recipe_none};
        REG_POWER: d.rdata = {22'h0, q.power};
        REG_AUTO_POWER: d.rdata = {22'h0, q.autopwr};
        REG_SLOTS: d.rdata = q.slots;
        default: d.rdata = 32'h0;
      endcase
    end

    rx_fire = rx_valid_in && rx_ready_out;
    at_seen = rx_fire && (b == CH_AT);
    case (q.st)
      ST_IDLE: ;
      ST_HDR: begin
        if (rx_fire && !at_seen) begin
          if (b == CH_CR) begin
            d.bad = 1'b1;
            d.st = ST_EXEC;
          end else begin
            d.hdr[q.hcnt] = b;
            d.hcnt = q.hcnt + 2'h1;
            if (q.hcnt == 2'h3) begin
              d.st = ST_TAIL;
            end
          end
        end
      end
      ST_TAIL: begin
        if (rx_fire && !at_seen) begin
          if (b == CH_COLON) begin
            d.kind = KIND_DATA;
            d.st = ST_DATA;
          end else if (b == CH_QUEST) begin
            d.kind = KIND_REQ;
            d.st = ST_QEND;
          end else if (b == CH_CR) begin
            d.st = ST_EXEC;
          end else begin
            d.bad = 1'b1;
            d.st = ST_SKIP;
          end
        end
      end
      ST_DATA: begin
        if (rx_fire && !at_seen) begin
          if (b == CH_CR) begin
            d.st = ST_EXEC;
          end else begin
            // Only the first few characters are kept; the count runs on
            // so that an overlong field is still caught.
            if (q.dlen < 5'(DBUF_DEPTH)) begin
              d.dbuf[3'(q.dlen)] = b;
            end
            if (q.dlen != DATA_LEN_SAT) begin
              d.dlen = q.dlen + 5'h1;
            end
            if ((b >= CH_LOW_A) && (b <= CH_LOW_Z)) begin
              d.lower = 1'b1;
            end
          end
        end
      end
      ST_QEND, ST_SKIP: begin
        if (rx_fire && !at_seen) begin
          if (b == CH_CR) begin
            d.st = ST_EXEC;
          end else begin
            d.bad = 1'b1;
          end
        end
      end
      ST_EXEC: begin
        d.pay = '0;
        d.pay[0] = CH_O;
        d.pay[1] = CH_K;
        d.plen = 4'h2;
        if (q.bad || !known) begin
          err = ERR_UNREC;
        end else if (q.lower || (q.dlen > MAX_DATA_LEN)) begin
          err = ERR_DATA;
        end else if (cat == CAT_FORMAT) begin
          if (q.kind == KIND_REQ) begin
            d.pay[0] = q.fmt_sci ? CH_E : CH_D;
            d.plen = 4'h1;
          end else if ((q.kind != KIND_DATA) || (q.dlen != 5'h1) ||
                       ((d0 != CH_E) && (d0 != CH_D))) begin
            err = ERR_DATA;
          end else begin
            d.fmt_sci = (d0 == CH_E);
          end
        end else if (cat == CAT_DIAG) begin
          if (q.kind != KIND_REQ) begin
            err = ERR_INAPP;
          end else begin
            for (int i = 0; i < int'(SLOT_COUNT); i++) begin
              d.pay[i] = CH_0 + {4'h0, q.slots[4*i +: 4]};
            end
            d.plen = 4'(SLOT_COUNT);
          end
        end else if (!idok) begin
          err = ERR_UNREC;
        end else if (!inr) begin
          err = ERR_INAPP;
        end else if (cat == CAT_CAL) begin
          if (q.kind == KIND_REQ) begin
            err = ERR_INAPP;
          end else if ((num == NUM_ZERO) &&
                       (q.ion[ch] || !q.zero_en[ch])) begin
            err = ERR_INAPP;
          end else if ((num == NUM_SPAN) && (!q.span_en[ch] ||
                       (q.thermal[ch] && !q.n2[ch]))) begin
            err = ERR_INAPP;
          end
        end else if (cat == CAT_CTRL) begin
          if ((q.kind != KIND_DATA) || (q.dlen != 5'h1) ||
              ((d0 != CH_A) && (d0 != CH_P) && (d0 != CH_M))) begin
            err = ERR_DATA;
          end else if ((d0 != CH_M) && q.recipe_none) begin
            err = ERR_INAPP;
          end else begin
            d.ctrl_mode = (d0 == CH_A) ? 2'h1 : (d0 == CH_P) ? 2'h2 :
                          RST_CTRL_MODE;
          end
        end else if (q.kind == KIND_REQ) begin
          // Power readback works on an off channel; every other reading of an off channel,
          // and every reading but power and degas of a high-degas channel, fails.
          if ((num != CH_1) && (!q.power[ch] || (num != CH_5 &&
              q.degas_on && q.degas_hi && (q.degas_ch == ch)))) begin
            err = ERR_INAPP;
          end else begin
            d.plen = 4'h1;
            case (num)
              CH_1: begin
                d.pay[0] = CH_O;
                d.pay[1] = q.power[ch] ? CH_N : CH_F;
                d.pay[2] = CH_F;
                d.plen = q.power[ch] ? 4'h2 : 4'h3;
              end
              CH_2: d.pay[0] = q.autopwr[ch] ? CH_E : CH_D;
              CH_3: d.pay[0] = CH_0 + {4'h0, q.refch[ch]};
              CH_4: begin
                for (int i = 0; i < int'(PRESS_CHARS); i++) begin
                  d.pay[i] = q.press[ch][i];
                end
                if (q.press_len[ch] == 3'h0) begin
                  d.pay[0] = CH_0;
                end else begin
                  d.plen = {1'b0, q.press_len[ch]};
                end
              end
              default: begin
                d.pay[0] = !(q.degas_on && (q.degas_ch == ch)) ? CH_O :
                           q.degas_hi ? CH_H : CH_L;
              end
            endcase
          end
        end else if (q.kind != KIND_DATA) begin
          err = ERR_DATA;
        end else if ((num != CH_1) && !q.power[ch]) begin
          err = ERR_INAPP;
        end else begin
          // There is no busy state for a gauge that is still starting up,
          // so its messages are taken at once.
          case (num)
            CH_1: begin
              if (!is_on && !is_off) begin
                err = ERR_DATA;
              end else if (q.present[ch]) begin
                d.power[ch] = is_on;
                if (is_off && (q.degas_ch == ch)) begin
                  d.degas_on = 1'b0;
                end
              end
            end
            CH_2: begin
              if (!q.ion[ch]) begin
                err = ERR_INAPP;
              end else if ((q.dlen != 5'h1) ||
                           ((d0 != CH_E) && (d0 != CH_D))) begin
                err = ERR_DATA;
              end else begin
                d.autopwr[ch] = (d0 == CH_E);
              end
            end
            CH_3: begin
              if ((q.dlen != 5'h1) || !is_digit(d0)) begin
                err = ERR_DATA;
              end else begin
                d.refch[ch] = 4'(d0 - CH_0);
              end
            end
            CH_4: begin
              if (!numeric) begin
                err = ERR_DATA;
              end else begin
                for (int i = 0; i < int'(PRESS_CHARS); i++) begin
                  d.press[ch][i] = q.dbuf[i];
                end
                d.press_len[ch] = 3'(q.dlen);
              end
            end
            default: begin
              if (!q.hot[ch]) begin
                err = ERR_INAPP;
              end else if ((q.dlen != 5'h1) || ((d0 != CH_L) &&
                           (d0 != CH_H) && (d0 != CH_O))) begin
                err = ERR_DATA;
              end else if ((d0 != CH_O) && q.degas_on &&
                           (q.degas_ch != ch)) begin
                err = ERR_INAPP;
              end else if (d0 == CH_O) begin
                if (q.degas_ch == ch) begin
                  d.degas_on = 1'b0;
                end
              end else begin
                d.degas_on = 1'b1;
                d.degas_hi = (d0 == CH_H);
                d.degas_ch = ch;
              end
            end
          endcase
        end
        if (err != ERR_NONE) begin
          d.pay[0] = CH_E;
          d.pay[1] = CH_1;
          d.pay[2] = (err == ERR_DATA) ? CH_2 : CH_1;
          d.pay[3] = (err == ERR_UNREC) ? CH_1 : CH_2;
          d.plen = 4'h4;
        end
        d.tidx = 4'h0;
        d.txb = CH_AT;
        d.st = ST_SEND;
      end
      ST_SEND: begin
        if (tx_ready_in) begin
          if (q.tidx == (q.plen + 4'h6)) begin
            d.st = ST_IDLE;
          end else begin
            d.tidx = q.tidx + 4'h1;
            d.txb = reply_byte(q, q.tidx + 4'h1);
          end
        end
      end
      default: d.st = ST_IDLE;
    endcase

    if (at_seen) begin
      // A fresh start marker throws away whatever was half received.
      d.st = ST_HDR;
      d.hcnt = 2'h0;
      d.bad = 1'b0;
      d.lower = 1'b0;
      d.dlen = 5'h0;
      d.kind = KIND_CMD;
    end
  end

  // The format choice lives only here, so every reset returns it to D.
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule

// file: sim/serial_gauge_command_parser_asserts.sv
// Port-level checks for the serial gauge command parser.
module gauge_parser_asserts
  import gauge_cmd_pkg::*;
(
  input wire logic mclk_in,
  input wire logic reset_n_in,
  input wire logic [7:0] rx_data_in,
  input wire logic rx_valid_in,
  input wire logic rx_ready_out,
  input wire logic [7:0] tx_data_out,
  input wire logic tx_valid_out,
  input wire logic tx_ready_in,
  input wire logic reg_wr_in,
  input wire logic [9:0] chan_power_out,
  input wire logic [9:0] chan_supply_out,
  input wire logic fmt_sci_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);
  logic cr_taken;
  assign cr_taken = rx_valid_in && rx_ready_out && rx_data_in == CH_CR;

  AST_CR_STALL: assert property (cr_taken |=> !rx_ready_out)
    else $error("input still ready after a return");
  AST_REPLY_START: assert property (cr_taken |-> ##2 tx_valid_out)
    else $error("reply did not start two cycles after a return");
  AST_REPLY_AT: assert property ($rose(tx_valid_out) |->
    tx_data_out == CH_AT) else $error("reply does not open with at-sign");
  AST_TX_HOLD: assert property (tx_valid_out && !tx_ready_in |=>
    tx_valid_out && $stable(tx_data_out)) else $error("reply byte lost");
  AST_TX_END_CR: assert property ($fell(tx_valid_out) |->
    $past(tx_data_out) == CH_CR) else $error("reply not ended by return");
  AST_TX_BLOCKS_RX: assert property (tx_valid_out |-> !rx_ready_out)
    else $error("input taken while replying");
  AST_FMT_AT_EXEC: assert property ($changed(fmt_sci_out) |->
    !rx_ready_out) else $error("format changed outside a command");
  // With the supply mask untouched, a supply may only drop with its power.
  AST_SUPPLY: assert property (!reg_wr_in |=>
    ($past(chan_supply_out) & ~chan_supply_out &
     ~($past(chan_power_out) & ~chan_power_out)) == 10'h0)
    else $error("channel supply dropped without power off");
endmodule

bind serial_gauge_command_parser gauge_parser_asserts u_chk (.*);

// file: sim/gauge_host_model.sv
// Host model: sends framed messages and sinks replies with stalls.
module gauge_host_model (
  input wire logic clk_in,
  input wire logic stall_in,
  input wire logic rx_ready_in,
  input wire logic tx_valid_in,
  output logic [7:0] rx_data_out,
  output logic rx_valid_out,
  output logic tx_ready_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    rx_valid_out = 1'b0;
    rx_data_out = 8'hFF;
    tx_ready_out = 1'b0;
  end
  always @(posedge clk_in) tx_ready_out <= !stall_in;

  // Each message goes out whole, closed by a return.
  // A released data line shows the inverse so a stale byte never matches.
  task automatic send(input string m);
    logic [7:0] c;
    for (int i = 0; i <= m.len(); i++) begin
      c = (i == m.len()) ? 8'h0D : m[i];
      @(posedge clk_in);
      rx_valid_out <= 1'b1;
      rx_data_out <= c;
      do @(negedge clk_in); while (!rx_ready_in);
    end
    @(posedge clk_in);
    rx_valid_out <= 1'b0;
    rx_data_out <= ~c;
  endtask
endmodule

// file: sim/serial_gauge_command_parser_tb_top.sv
// Self-checking bench for the serial gauge command parser.
module serial_gauge_command_parser_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import gauge_cmd_pkg::*;
  logic mclk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic rx_valid_in, rx_ready_out, tx_valid_out, tx_ready_in;
  logic [7:0] rx_data_in, tx_data_out;
  logic [5:0] reg_addr_in = '0;
  logic [31:0] reg_wdata_in = '0;
  logic [31:0] reg_rdata_out;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic fmt_sci_out, degas_active_out, degas_high_out;
  logic [9:0] chan_power_out, chan_supply_out, auto_power_out;
  logic [9:0][3:0] ref_chan_out;
  logic [1:0] ctrl_mode_out;
  logic [3:0] degas_chan_out;
  logic [9:0][2:0] shutoff_len_out;
  logic [9:0][5:0][7:0] shutoff_press_out;
  logic [15:0] seed = 16'h94CA;
  logic [7:0] q[$];
  string s;
  int miscompares = 0;
  int n_checks = 0;

  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  always #10 mclk_in = ~mclk_in;
  always @(posedge mclk_in) seed <= lfsr(seed);

  serial_gauge_command_parser dut (.*);
  gauge_host_model host (.clk_in(mclk_in), .stall_in(seed[1:0] == 2'h0),
    .rx_ready_in(rx_ready_out), .tx_valid_in(tx_valid_out),
    .rx_data_out(rx_data_in), .rx_valid_out(rx_valid_in),
    .tx_ready_out(tx_ready_in));

  task automatic chk(input string n, input logic [31:0] v, e);
    n_checks++;
    if (v !== e) begin
      miscompares++;
      $display("unexpected %s: expected %0h seen %0h", n, e, v);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // A reply byte with nothing queued is compared against unknown and fails.
  always @(negedge mclk_in)
    if (tx_valid_out && tx_ready_in)
      chk("reply byte", tx_data_out, q.size() ? q.pop_front() : 'x);

  task automatic cmd(input string c, r);
    foreach (r[i]) q.push_back(r[i]);
    q.push_back(CH_CR);
    host.send(c);
    for (int i = 0; i < 300 && (q.size() > 0 || tx_valid_out); i++)
      @(posedge mclk_in);
    chk("reply left", q.size(), 0);
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge mclk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    @(posedge mclk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge mclk_in);
    reg_rd_in <= 1'b0;
    @(negedge mclk_in);
    chk("read data", reg_rdata_out, e);
  endtask
  task automatic rst();
    reset_n_in <= 1'b0;
    repeat (12) @(posedge mclk_in);
    reset_n_in <= 1'b1;
  endtask

  initial begin
    #400000;
    miscompares++;
    give_verdict();
  end

  initial begin
    s = "@0811:";
    repeat (27) s = {s, "A"};
    rst();
    cmd("@508 ?", "@508 :D");
    cmd("@508 :E", "@508 :OK");
    chk("format", fmt_sci_out, 1);
    cmd("@508x?", "@508x:E");
    cmd("@508 :D", "@508 :OK");
    chk("format", fmt_sci_out, 0);
    cmd("@0811:ON", "@0811:OK");
    cmd("@0811?", "@0811:OFF");
    cmd("@777 ", "@777 :E111");
    cmd("@0821:E", "@0821:E112");
    cmd("@992 :1", "@992 :E112");
    wr(REG_PRESENT, 32'h3FF);
    wr(REG_KEEP_SUPPLY, 32'h200);
    rd(REG_PRESENT, 32'h3FF);
    rd(REG_POWER, 32'h0);
    cmd("@0810:ON", "@0810:OK");
    chk("power", chan_power_out, 32'h200);
    cmd("@0810:OFF", "@0810:OK");
    chk("supply", {chan_power_out, chan_supply_out}, 32'h200);
    cmd("@0811:ON", "@0811:OK");
    cmd("@0811?", "@0811:ON");
    cmd("@0811:on", "@0811:E122");
    cmd(s, "@0811:E122");
    cmd("@0851:L", "@0851:E112");
    wr(REG_ION, 32'h1);
    wr(REG_HOT_CATH, 32'h1);
    cmd("@0851:H", "@0851:OK");
    chk("degas", {degas_active_out, degas_high_out}, 3);
    cmd("@0821?", "@0821:E112");
    cmd("@0851:O", "@0851:OK");
    chk("degas off", degas_active_out, 0);
    cmd("@0821:E", "@0821:OK");
    cmd("@0831:2", "@0831:OK");
    chk("auto", {auto_power_out[0], ref_chan_out[0]}, 5'h12);
    cmd("@0841?", "@0841:0");
    cmd("@0841:1E-3", "@0841:OK");
    cmd("@0841?", "@0841:1E-3");
    chk("shutoff", shutoff_press_out[0][3:0], 32'h332D4531);
    chk("shutoff len", shutoff_len_out[0], 4);
    wr(REG_HOT_CATH, 32'h3);
    cmd("@0812:ON", "@0812:OK");
    cmd("@0852:L", "@0852:OK");
    chk("degas on", degas_active_out, 1);
    chk("degas ch", {degas_high_out, degas_chan_out}, 5'h1);
    cmd("@0852?", "@0852:L");
    cmd("@0851:H", "@0851:E112");
    cmd("@0852:O", "@0852:OK");
    cmd("@0711", "@0711:E112");
    wr(REG_SPAN_EN, 32'h1);
    wr(REG_THERMAL, 32'h1);
    cmd("@0721", "@0721:E112");
    wr(REG_GAS_N2, 32'h1);
    cmd("@0721", "@0721:OK");
    wr(REG_MISC, 32'h1);
    cmd("@3011:A", "@3011:E112");
    wr(REG_MISC, 32'h0);
    cmd("@3011:P", "@3011:OK");
    chk("mode", ctrl_mode_out, 2);
    wr(REG_SLOTS, 32'h8531);
    cmd("@992 ?", "@992 :1358");
    cmd("@0811:@508 :E", "@508 :OK");
    chk("format", fmt_sci_out, 1);
    rst();
    cmd("@508 ?", "@508 :D");
    give_verdict();
  end
endmodule
